// ==== src/csmp_device.sv ====
`timescale 1ns/1ns
`default_nettype none
module csmp_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // configuration: high selects root port mode
  input wire logic root_port_mode_i,
  // access port
  csmp_if.dev port
);
  typedef enum logic [1:0] {CSMP_IDLE, CSMP_BUSY, CSMP_DONE} csmp_state_t;

  // sequencing state
  csmp_state_t state_q;
  csmp_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // answer registers
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic done_q;
  logic done_d;

  // storage has no reset so it maps onto plain memory
  logic [31:0] cfg_mem [csmp_pkg::NFUNC][csmp_pkg::NREG];
  logic [31:0] mgmt_mem [csmp_pkg::MGMT_NREG];

  // address decode
  logic mgmt_sel;
  logic [7:0] func;
  logic [9:0] regn;
  logic fhit;
  logic rhit;
  logic mhit;
  logic type1;
  logic ovr;

  // storage index, only the low bits are kept
  logic func_idx;
  logic [5:0] cfg_idx;
  logic [3:0] mgmt_idx;

  // read and write path
  logic [31:0] cfg_word;
  logic [31:0] mgmt_word;
  logic [31:0] cur;
  logic [3:0] lane_we;
  logic [31:0] merged;
  logic finish;
  logic wr_commit;
  logic rd_sample;
  logic cfg_we;
  logic mgmt_we;

  assign mgmt_sel = port.addr[csmp_pkg::SPACE_BIT];
  assign func = port.addr[csmp_pkg::FUNC_MSB:csmp_pkg::FUNC_LSB];
  assign regn = port.addr[csmp_pkg::REG_MSB:csmp_pkg::REG_LSB];
  // only part of each space is backed; the hit flags guard the rest
  assign fhit = func < 8'(csmp_pkg::NFUNC);
  assign rhit = regn < 10'(csmp_pkg::NREG);
  assign mhit = regn < 10'(csmp_pkg::MGMT_NREG);
  assign func_idx = func[0];
  assign cfg_idx = regn[5:0];
  assign mgmt_idx = regn[3:0];
  // management registers are never type-1 header registers
  assign type1 = !mgmt_sel && (regn >= csmp_pkg::T1_FIRST) &&
    (regn <= csmp_pkg::T1_LAST);
  // override counts only for root port type-1 writes
  assign ovr = port.rootport_ro_override && root_port_mode_i && type1;

  // unbacked indices read as the reset word, writes to them are dropped
  always_comb begin
    cfg_word = csmp_pkg::RESET_WORD;
    if (fhit && rhit) begin
      cfg_word = cfg_mem[func_idx][cfg_idx];
    end
  end

  always_comb begin
    mgmt_word = csmp_pkg::RESET_WORD;
    if (mhit) begin
      mgmt_word = mgmt_mem[mgmt_idx];
    end
  end

  assign cur = mgmt_sel ? mgmt_word : cfg_word;

  // read-only bytes of type-1 registers pass only under override
  always_comb begin
    lane_we = port.byte_enable;
    if (type1 && !ovr) begin
      lane_we = port.byte_enable & ~csmp_pkg::T1_RO_BYTES;
    end
  end

  // a lane keeps its stored byte unless its enable is set
  for (genvar g = 0; g < csmp_pkg::BE_W; g++) begin : g_lane
    assign merged[g*8 +: 8] = lane_we[g] ? port.write_data[g*8 +: 8] :
      cur[g*8 +: 8];
  end

  // latency lets the strobe settle; request must stay put until done
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    finish = 1'h0;
    case (state_q)
      CSMP_IDLE: begin
        if (port.write || port.read) begin
          state_d = CSMP_BUSY;
          cnt_d = 2'h1;
        end
      end
      CSMP_BUSY: begin
        // commit or sample happens on this edge only
        if (cnt_q == csmp_pkg::DONE_LAT) begin
          finish = 1'h1;
          state_d = CSMP_DONE;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      CSMP_DONE: begin
        // one idle cycle so a held strobe is not taken twice
        // the requester drops its strobe at this edge
        state_d = CSMP_IDLE;
      end
      default: begin
        state_d = CSMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= CSMP_IDLE;
      cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // write wins if both strobes stand; a well-behaved requester never does that
  always_comb begin
    wr_commit = finish && port.write;
    rd_sample = finish && !port.write;
    done_d = finish;
    rdata_d = rdata_q;
    if (rd_sample) begin
      rdata_d = cur;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= csmp_pkg::RESET_WORD;
      done_q <= 1'h0;
    end else begin
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // a write is committed once, at the edge that raises done
  always_comb begin
    cfg_we = 1'h0;
    mgmt_we = 1'h0;
    if (wr_commit && !srst_i) begin
      if (mgmt_sel) begin
        mgmt_we = mhit;
      end else begin
        cfg_we = fhit && rhit;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (mgmt_we) begin
      mgmt_mem[mgmt_idx] <= merged;
    end
  end

  always_ff @(posedge clk_i) begin
    if (cfg_we) begin
      cfg_mem[func_idx][cfg_idx] <= merged;
    end
  end

  assign port.read_data = rdata_q;
  assign port.read_write_done = done_q;
endmodule // csmp_device
`default_nettype wire

// ==== shared/csmp_pkg.sv ====
`default_nettype none
package csmp_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // address fields
  localparam int SPACE_BIT = 18;
  localparam int FUNC_MSB = 17;
  localparam int FUNC_LSB = 10;
  localparam int REG_MSB = 9;
  localparam int REG_LSB = 0;
  localparam int FUNC_W = 8;
  localparam int REG_W = 10;
  // storage modelled per space: words per space kept small
  localparam int NFUNC = 2;
  localparam int NREG = 64;
  localparam int MGMT_NREG = 16;
  // type-1 header registers, dword index within a function
  localparam logic [9:0] T1_FIRST = 10'h004;
  localparam logic [9:0] T1_LAST = 10'h00f;
  // bytes of a type-1 register that are read-only to ordinary writes
  localparam logic [3:0] T1_RO_BYTES = 4'hc;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // busy count that ends an access; done rises three clocks after the strobe
  localparam logic [1:0] DONE_LAT = 2'h2;
endpackage
`default_nettype wire

// ==== shared/csmp_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface csmp_if;
  logic [18:0] addr;
  logic write;
  logic [31:0] write_data;
  logic [3:0] byte_enable;
  logic read;
  logic rootport_ro_override;
  logic [31:0] read_data;
  logic read_write_done;
  modport dev (
    input addr, write, write_data, byte_enable, read, rootport_ro_override,
    output read_data, read_write_done
  );
  modport req (
    output addr, write, write_data, byte_enable, read, rootport_ro_override,
    input read_data, read_write_done
  );
endinterface
`default_nettype wire

// ==== src/csmp_requester.sv ====
`timescale 1ns/1ns
`default_nettype none
module csmp_requester (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // user request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [18:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [3:0] req_be_i,
  input wire logic req_override_i,
  // user answer
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [31:0] resp_rdata_o,
  // access port
  csmp_if.req port
);
  typedef enum logic {CSMR_IDLE, CSMR_WAIT} csmp_req_state_t;

  csmp_req_state_t state_q, state_d;
  logic [18:0] addr_q, addr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] be_q, be_d;
  logic wr_q, wr_d, rd_q, rd_d, ovr_q, ovr_d, rdy_q, rdy_d, rv_q, rv_d;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    be_d = be_q;
    wr_d = wr_q;
    rd_d = rd_q;
    ovr_d = ovr_q;
    rdy_d = rdy_q;
    rv_d = 1'h0;
    rdata_d = rdata_q;
    case (state_q)
      CSMR_IDLE: begin
        rdy_d = 1'h1;
        if (req_valid_i && rdy_q) begin
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          be_d = req_be_i;
          wr_d = req_write_i;
          rd_d = !req_write_i;
          ovr_d = req_override_i;
          rdy_d = 1'h0;
          state_d = CSMR_WAIT;
        end
      end
      CSMR_WAIT: begin
        // hold everything until done, one operation at a time
        if (port.read_write_done) begin
          wr_d = 1'h0;
          rd_d = 1'h0;
          ovr_d = 1'h0;
          rv_d = 1'h1;
          rdata_d = port.read_data;
          state_d = CSMR_IDLE;
        end
      end
      default: state_d = CSMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= CSMR_IDLE;
      addr_q <= 19'h0;
      wdata_q <= 32'h0;
      be_q <= 4'h0;
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      ovr_q <= 1'h0;
      rdy_q <= 1'h0;
      rv_q <= 1'h0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      be_q <= be_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      ovr_q <= ovr_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
    end
  end

  assign port.addr = addr_q;
  assign port.write = wr_q;
  assign port.read = rd_q;
  assign port.write_data = wdata_q;
  assign port.byte_enable = be_q;
  assign port.rootport_ro_override = ovr_q;
  assign req_ready_o = rdy_q;
  assign resp_valid_o = rv_q;
  assign resp_rdata_o = rdata_q;
endmodule // csmp_requester
`default_nettype wire

// ==== testbench/csmp_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module csmp_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // link signals
  input wire logic [18:0] addr,
  input wire logic write,
  input wire logic [31:0] write_data,
  input wire logic [3:0] byte_enable,
  input wire logic read,
  input wire logic rootport_ro_override,
  input wire logic [31:0] read_data,
  input wire logic read_write_done
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire strb = write | read;
  sequence s_busy; !read_write_done [*3]; endsequence
  sequence s_pulse; read_write_done ##1 !read_write_done; endsequence
  AST_LATENCY: assert property ($rose(strb) |-> s_busy ##1 s_pulse)
    else $error("done late or early");
  AST_PULSE: assert property (read_write_done |=> !read_write_done)
    else $error("done longer than one cycle");
  AST_CAUSE: assert property (read_write_done |-> strb && $past(strb, 3))
    else $error("done without request");
  AST_RELEASE: assert property (read_write_done |=> !strb)
    else $error("strobe held after done");
  AST_EXCL: assert property (!(write && read))
    else $error("read and write together");
  AST_HOLD: assert property (strb && !read_write_done |=>
    $stable({addr, write_data, byte_enable, rootport_ro_override, write, read}))
    else $error("request changed before done");
  AST_RDATA: assert property ($changed(read_data) |-> read_write_done && read)
    else $error("read data moved outside a read");
  AST_RESET: assert property ($fell(srst_i) |-> !read_write_done && !strb && read_data == 32'h0)
    else $error("link not idle after reset");
endmodule // csmp_sva
`default_nettype wire

// ==== testbench/tb_config_space_mgmt_port.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_config_space_mgmt_port;
  logic clk_i;
  logic srst_i;
  logic root_port_mode_i;
  logic req_valid_i;
  logic req_write_i;
  logic [18:0] req_addr_i;
  logic [31:0] req_wdata_i;
  logic [3:0] req_be_i;
  logic req_override_i;
  logic req_ready_o;
  logic resp_valid_o;
  logic [31:0] resp_rdata_o;
  int failures;
  int check_count;
  csmp_if bus ();
  csmp_device csmp_device_i (.clk_i(clk_i), .srst_i(srst_i), .root_port_mode_i(root_port_mode_i),
    .port(bus.dev));
  csmp_requester csmp_requester_i (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_be_i(req_be_i), .req_override_i(req_override_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .resp_rdata_o(resp_rdata_o), .port(bus.req));
  csmp_sva csmp_sva_i (.clk_i(clk_i), .srst_i(srst_i), .addr(bus.addr), .write(bus.write),
    .write_data(bus.write_data), .byte_enable(bus.byte_enable), .read(bus.read),
    .rootport_ro_override(bus.rootport_ro_override), .read_data(bus.read_data),
    .read_write_done(bus.read_write_done));
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic op(input logic w, input logic [18:0] a, input logic [31:0] d,
                    input logic [3:0] be, input logic ov, output logic [31:0] r);
    int n;
    n = 0;
    @(negedge clk_i);
    while (req_ready_o !== 1'h1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, req_ready_o}, 32'h1);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_be_i, req_override_i} =
      {1'h1, w, a, d, be, ov};
    @(negedge clk_i);
    req_valid_i = 1'h0;
    chk({31'h0, req_ready_o}, 32'h0);
    n = 0;
    // answer stands one cycle, so look just after each edge
    while (resp_valid_o !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({31'h0, resp_valid_o}, 32'h1);
    r = resp_rdata_o;
    @(posedge clk_i);
    #1;
    chk({31'h0, resp_valid_o}, 32'h0);
  endtask
  task automatic wr(input logic [18:0] a, input logic [31:0] d, input logic [3:0] be, input logic ov);
    logic [31:0] r;
    op(1'h1, a, d, be, ov, r);
  endtask
  task automatic rd(input logic [18:0] a, input logic [31:0] exp);
    logic [31:0] r;
    op(1'h0, a, 32'h0, 4'h0, 1'h0, r);
    chk(r, exp);
  endtask
  task automatic t_bytes;
    wr(19'h00010, 32'h1122_3344, 4'hf, 1'h0);
    wr(19'h00010, 32'haabb_ccdd, 4'h5, 1'h0);
    rd(19'h00010, 32'h11bb_33dd);
    wr(19'h00010, 32'h0, 4'ha, 1'h1);
    rd(19'h00010, 32'h00bb_00dd);
  endtask
  task automatic t_space;
    wr(19'h00003, 32'ha0a0_0001, 4'hf, 1'h0);
    wr(19'h00403, 32'hb0b0_0002, 4'hf, 1'h0);
    wr(19'h40003, 32'hc0c0_0003, 4'hf, 1'h0);
    rd(19'h00003, 32'ha0a0_0001);
    rd(19'h00403, 32'hb0b0_0002);
    rd(19'h40003, 32'hc0c0_0003);
    wr(19'h40004, 32'hdddd_eeee, 4'hf, 1'h0);
    rd(19'h40004, 32'hdddd_eeee);
    rd(19'h00010, 32'h00bb_00dd);
  endtask
  task automatic t_type1;
    wr(19'h00004, 32'h1234_5678, 4'hf, 1'h1);
    rd(19'h00004, 32'h1234_5678);
    wr(19'h00004, 32'hffff_ffff, 4'hf, 1'h0);
    rd(19'h00004, 32'h1234_ffff);
    @(negedge clk_i);
    root_port_mode_i = 1'h0;
    wr(19'h00004, 32'h0, 4'hf, 1'h1);
    rd(19'h00004, 32'h1234_0000);
  endtask
  task automatic t_reset;
    @(negedge clk_i);
    srst_i = 1'h1;
    repeat (3) @(negedge clk_i);
    chk({30'h0, req_ready_o, resp_valid_o}, 32'h0);
    srst_i = 1'h0;
    rd(19'h00003, 32'ha0a0_0001);
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    srst_i = 1'h1;
    root_port_mode_i = 1'h1;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_be_i, req_override_i} = '0;
    repeat (3) @(negedge clk_i);
    srst_i = 1'h0;
    t_bytes;
    t_space;
    t_type1;
    t_reset;
    conclude;
  end
  // about 20 transfers of under ten cycles each, so 4000 cycles is ample
  initial begin
    #200000;
    failures++;
    conclude;
  end
endmodule // tb_config_space_mgmt_port
`default_nettype wire
